// ---- iiu_defs.vh ----
`ifndef IIU_DEFS_VH
`define IIU_DEFS_VH
`define IIU_REG_CTRL      12'h000
`define IIU_REG_EDGE      12'h004
`define IIU_REG_FUNC      12'h008
`define IIU_REG_STATUS    12'h00c
`define IIU_REG_MASK      12'h010
`define IIU_REG_TASK      12'h014
`define IIU_REG_LEVEL     12'h018
`define IIU_REG_TARGET0   12'h020
`define IIU_REG_COUNT0    12'h040
`define IIU_EDGE_RISE     16'h0000
`define IIU_EDGE_FALL     16'h0001
`define IIU_EN_DIRECT     16'h0000
`define IIU_EN_DISABLE    16'h0001
`define IIU_EN_CNT_DOWN   16'h0002
`define IIU_EN_CNT_UP     16'h0003
`define IIU_TASK_BASE     8'h8c
`define IIU_FUNC_INTR     3'h0
`define IIU_FUNC_NORMAL   3'h1
`define IIU_FUNC_QUICK    3'h2
`define IIU_FUNC_COUNTER  3'h3
`define IIU_FUNC_ORIGIN   3'h4
`endif

// ---- iiu_interrupt_input_unit.v ----
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "iiu_defs.vh"
module iiu_interrupt_input_unit #(
  parameter        NUM_IN   = 8,
  parameter        CNT_W    = 16,
  parameter [7:0]  BOOT_EDGE = 8'h00
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [7:0]  terminal_in,
  output reg  [7:0]  normal_in_ff,
  output reg  [7:0]  quick_in_ff,
  output reg  [7:0]  counter_in_ff,
  output reg  [7:0]  origin_in_ff,
  output reg  [7:0]  task_start_ff,
  output reg  [7:0]  task_num_ff,
  output reg         irq_ff
);

// --------------------------------------------------------------------
// Helpers
// --------------------------------------------------------------------
function [7:0] lowest_bit;
  input [7:0] v;
  integer k;
  begin
    lowest_bit = 8'h00;
    for (k = 7; k >= 0; k = k - 1) begin
      if (v[k]) begin
        lowest_bit = k[7:0];
      end
    end
  end
endfunction

// --------------------------------------------------------------------
// State
// --------------------------------------------------------------------
reg  [7:0]       sync1_ff;
reg  [7:0]       sync2_ff;
reg  [7:0]       prev_ff;
reg  [7:0]       edge_sel_ff;
reg  [7:0]       edge_cmd_ff;
reg  [7:0]       enable_ff;
reg  [7:0]       cnt_mode_ff;
reg  [7:0]       cnt_up_ff;
reg  [23:0]      func_ff;
reg  [7:0]       status_ff;
reg  [7:0]       mask_ff;
reg  [CNT_W-1:0] target_ff [0:7];
reg  [CNT_W-1:0] count_ff  [0:7];
reg              boot_ff;
reg              dph_ff;
reg              dwr_ff;
reg  [11:0]      daddr_ff;
reg  [7:0]       nxt_event;
reg  [7:0]       nxt_start;
reg  [7:0]       sel_intr;
integer          i;

wire       addr_ok = hsel & hready & htrans[1];
wire       wr_now  = dph_ff & dwr_ff & clk_en;
wire [2:0] idx     = daddr_ff[4:2];

// --------------------------------------------------------------------
// Edge detection and task start
// --------------------------------------------------------------------
always @* begin
  for (i = 0; i < 8; i = i + 1) begin
    sel_intr[i]  = (func_ff[3*i +: 3] == `IIU_FUNC_INTR);
    nxt_event[i] = sel_intr[i] &
                   (edge_sel_ff[i] ? (prev_ff[i] & ~sync2_ff[i])
                                   : (~prev_ff[i] & sync2_ff[i]));
    nxt_start[i] = 1'b0;
    if (nxt_event[i] & enable_ff[i]) begin
      if (!cnt_mode_ff[i]) begin
        nxt_start[i] = 1'b1;
      end else if (cnt_up_ff[i] ? (count_ff[i] + 1'b1 >= target_ff[i])
                                : (count_ff[i] <= {{(CNT_W-1){1'b0}}, 1'b1})) begin
        nxt_start[i] = 1'b1;
      end
    end
  end
end

// --------------------------------------------------------------------
// Write decode
// --------------------------------------------------------------------
// Command word: input number in 18:16, code in 15:0
wire [11:0] tgt_base = `IIU_REG_TARGET0;
wire [11:0] cnt_base = `IIU_REG_COUNT0;
wire [2:0]  cmd_in   = hwdata[18:16];
wire [15:0] cmd_code = hwdata[15:0];
wire        wr_edge  = wr_now & (daddr_ff == `IIU_REG_EDGE);
wire        wr_ctrl  = wr_now & (daddr_ff == `IIU_REG_CTRL);
wire        wr_func  = wr_now & (daddr_ff == `IIU_REG_FUNC);
wire        wr_mask  = wr_now & (daddr_ff == `IIU_REG_MASK);
wire        wr_stat  = wr_now & (daddr_ff == `IIU_REG_STATUS);
wire        wr_tgt   = wr_now & (daddr_ff[11:5] == tgt_base[11:5]);

// --------------------------------------------------------------------
// Input synchroniser
// --------------------------------------------------------------------
// Only the second stage feeds logic; prev holds the older sample
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    sync1_ff <= 8'h00;
    sync2_ff <= 8'h00;
    prev_ff  <= 8'h00;
  end else if (clk_en) begin
    sync1_ff <= terminal_in;
    sync2_ff <= sync1_ff;
    prev_ff  <= sync2_ff;
  end
end

// --------------------------------------------------------------------
// Edge selection
// --------------------------------------------------------------------
// Startup edge loads once; a later command overrides it per input
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    boot_ff     <= 1'b0;
    edge_sel_ff <= 8'h00;
    edge_cmd_ff <= 8'h00;
  end else if (clk_en) begin
    if (!boot_ff) begin
      boot_ff     <= 1'b1;
      edge_sel_ff <= BOOT_EDGE;
    end
    if (wr_edge) begin
      edge_cmd_ff[cmd_in] <= 1'b1;
      edge_sel_ff[cmd_in] <= (cmd_code == `IIU_EDGE_FALL);
    end
  end
end

// --------------------------------------------------------------------
// Function select and mask
// --------------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    func_ff <= 24'h000000;
    mask_ff <= 8'h00;
  end else if (clk_en) begin
    if (wr_func) begin
      func_ff <= hwdata[23:0];
    end
    if (wr_mask) begin
      mask_ff <= hwdata[7:0];
    end
  end
end

// --------------------------------------------------------------------
// Enable and mode commands
// --------------------------------------------------------------------
// Unknown codes disable the input, like the disable code
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    enable_ff   <= 8'h00;
    cnt_mode_ff <= 8'h00;
    cnt_up_ff   <= 8'h00;
  end else if (clk_en && wr_ctrl) begin
    case (cmd_code)
      `IIU_EN_DIRECT: begin
        enable_ff[cmd_in]   <= 1'b1;
        cnt_mode_ff[cmd_in] <= 1'b0;
      end
      `IIU_EN_CNT_DOWN: begin
        enable_ff[cmd_in]   <= 1'b1;
        cnt_mode_ff[cmd_in] <= 1'b1;
        cnt_up_ff[cmd_in]   <= 1'b0;
      end
      `IIU_EN_CNT_UP: begin
        enable_ff[cmd_in]   <= 1'b1;
        cnt_mode_ff[cmd_in] <= 1'b1;
        cnt_up_ff[cmd_in]   <= 1'b1;
      end
      default: begin
        enable_ff[cmd_in] <= 1'b0;
      end
    endcase
  end
end

// --------------------------------------------------------------------
// Targets and edge counters
// --------------------------------------------------------------------
// Enabling a counter mode restarts the count from its start value
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    for (i = 0; i < 8; i = i + 1) begin
      target_ff[i] <= {CNT_W{1'b0}};
      count_ff[i]  <= {CNT_W{1'b0}};
    end
  end else if (clk_en) begin
    if (wr_tgt) begin
      target_ff[idx] <= hwdata[CNT_W-1:0];
    end
    for (i = 0; i < 8; i = i + 1) begin
      if (nxt_event[i] & enable_ff[i] & cnt_mode_ff[i]) begin
        if (nxt_start[i]) begin
          count_ff[i] <= cnt_up_ff[i] ? {CNT_W{1'b0}} : target_ff[i];
        end else begin
          count_ff[i] <= cnt_up_ff[i] ? count_ff[i] + 1'b1 : count_ff[i] - 1'b1;
        end
      end
    end
    if (wr_ctrl && cmd_code == `IIU_EN_CNT_DOWN) begin
      count_ff[cmd_in] <= target_ff[cmd_in];
    end else if (wr_ctrl && cmd_code == `IIU_EN_CNT_UP) begin
      count_ff[cmd_in] <= {CNT_W{1'b0}};
    end
  end
end

// --------------------------------------------------------------------
// Terminal routing
// --------------------------------------------------------------------
// Each terminal reaches only its selected function
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    normal_in_ff  <= 8'h00;
    quick_in_ff   <= 8'h00;
    counter_in_ff <= 8'h00;
    origin_in_ff  <= 8'h00;
  end else if (clk_en) begin
    for (i = 0; i < 8; i = i + 1) begin
      normal_in_ff[i]  <= sync2_ff[i] & (func_ff[3*i +: 3] == `IIU_FUNC_NORMAL);
      quick_in_ff[i]   <= sync2_ff[i] & (func_ff[3*i +: 3] == `IIU_FUNC_QUICK);
      counter_in_ff[i] <= sync2_ff[i] & (func_ff[3*i +: 3] == `IIU_FUNC_COUNTER);
      origin_in_ff[i]  <= sync2_ff[i] & (func_ff[3*i +: 3] == `IIU_FUNC_ORIGIN);
    end
  end
end

// --------------------------------------------------------------------
// Task start
// --------------------------------------------------------------------
// Task number keeps the lowest input started in the same cycle
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    task_start_ff <= 8'h00;
    task_num_ff   <= 8'h00;
  end else if (clk_en) begin
    task_start_ff <= nxt_start;
    if (|nxt_start) begin
      task_num_ff <= `IIU_TASK_BASE + lowest_bit(nxt_start);
    end
  end
end

// --------------------------------------------------------------------
// Bus address and data phase
// --------------------------------------------------------------------
// Zero wait states: read data is loaded at the address phase
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    dph_ff    <= 1'b0;
    dwr_ff    <= 1'b0;
    daddr_ff  <= 12'h000;
    hrdata    <= 32'h00000000;
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
  end else if (clk_en) begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
    dph_ff    <= addr_ok;
    dwr_ff    <= hwrite;
    if (addr_ok) begin
      daddr_ff <= haddr[11:0];
    end
    if (addr_ok && !hwrite) begin
      case (haddr[11:0])
        `IIU_REG_EDGE:   hrdata <= {16'h0000, edge_cmd_ff, edge_sel_ff};
        `IIU_REG_CTRL:   hrdata <= {8'h00, cnt_up_ff, cnt_mode_ff, enable_ff};
        `IIU_REG_FUNC:   hrdata <= {8'h00, func_ff};
        `IIU_REG_STATUS: hrdata <= {24'h000000, status_ff};
        `IIU_REG_MASK:   hrdata <= {24'h000000, mask_ff};
        `IIU_REG_TASK:   hrdata <= {24'h000000, task_num_ff};
        `IIU_REG_LEVEL:  hrdata <= {24'h000000, sync2_ff};
        default: begin
          if (haddr[11:5] == tgt_base[11:5]) begin
            hrdata <= {{(32-CNT_W){1'b0}}, target_ff[haddr[4:2]]};
          end else if (haddr[11:5] == cnt_base[11:5]) begin
            hrdata <= {{(32-CNT_W){1'b0}}, count_ff[haddr[4:2]]};
          end else begin
            hrdata <= 32'h00000000;
          end
        end
      endcase
    end
  end
end

// --------------------------------------------------------------------
// Status and interrupt
// --------------------------------------------------------------------
// Sticky status, set wins over write-one-to-clear
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    status_ff <= 8'h00;
    irq_ff    <= 1'b0;
  end else if (clk_en) begin
    if (wr_stat) begin
      status_ff <= (status_ff & ~hwdata[7:0]) | nxt_start;
    end else begin
      status_ff <= status_ff | nxt_start;
    end
    irq_ff <= |(status_ff & mask_ff);
  end
end

endmodule // iiu_interrupt_input_unit
`default_nettype wire

// ---- iiu_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module iiu_checker (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic [7:0] terminal_in,
  input wire logic [7:0] normal_in_ff,
  input wire logic [7:0] quick_in_ff,
  input wire logic [7:0] counter_in_ff,
  input wire logic [7:0] origin_in_ff,
  input wire logic [7:0] task_start_ff,
  input wire logic [7:0] task_num_ff,
  input wire logic       irq_ff
);
  // ----
  // Port relations
  // ----
  wire [7:0] fn_any = normal_in_ff | quick_in_ff | counter_in_ff | origin_in_ff;
  wire [7:0] fn_two = (normal_in_ff & (quick_in_ff | counter_in_ff | origin_in_ff)) |
                      (quick_in_ff & (counter_in_ff | origin_in_ff)) | (counter_in_ff & origin_in_ff);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  one_func_a: assert property (fn_two == 8'h00)
    else $error("terminal on two functions");
  in2_block_a: assert property (fn_any[2] |-> !task_start_ff[2])
    else $error("input 2 event while reused");
  level_pass_a: assert property ((fn_any & ~($past(terminal_in, 2) | $past(terminal_in, 3))) == 8'h00)
    else $error("function output without level");
  event_gap_a: assert property (task_start_ff != 8'h00 |=> (task_start_ff & $past(task_start_ff)) == 8'h00)
    else $error("event longer than one cycle");
  edge_cause_a: assert property ((task_start_ff & ~($past(terminal_in, 3) ^ $past(terminal_in, 4))) == 8'h00)
    else $error("event without terminal edge");
  task_range_a: assert property (task_num_ff == 8'h00 || (task_num_ff >= 8'h8c && task_num_ff <= 8'h93))
    else $error("task number out of range");
  task_hold_a: assert property ((task_start_ff == 8'h00) |-> $stable(task_num_ff))
    else $error("task number moved");
  cover property (task_start_ff != 8'h00);
  cover property ($rose(irq_ff));
  cover property (normal_in_ff[2]);
endmodule // iiu_checker
bind iiu_interrupt_input_unit iiu_checker chk_u (.*);
`default_nettype wire

// ---- iiu_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module iiu_sensor_model (
  input  wire logic       hclk,
  output var  logic [7:0] terminal_in
);
  // ----
  // Field sensor levels
  // ----
  initial terminal_in = 8'h00;
  task automatic drive(input int i, input logic v, input int n);
    @(posedge hclk);
    terminal_in[i] <= v;
    repeat (n) @(posedge hclk);
  endtask
endmodule // iiu_sensor_model
`default_nettype wire

// ---- tb_interrupt_input_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_input_unit;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        rdp = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq_ff;
  wire  [7:0]  terminal_in, normal_in_ff, task_start_ff;
  wire  [7:0]  quick_in_ff, counter_in_ff, origin_in_ff, task_num_ff;
  int          miscompares = 0;
  int          checked = 0;
  int          t;
  logic [31:0] rdq[$], evq[$];
  always #2 hclk = ~hclk;
  iiu_sensor_model sens_u (.hclk(hclk), .terminal_in(terminal_in));
  iiu_interrupt_input_unit dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .terminal_in(terminal_in), .normal_in_ff(normal_in_ff),
    .quick_in_ff(quick_in_ff), .counter_in_ff(counter_in_ff), .origin_in_ff(origin_in_ff),
    .task_start_ff(task_start_ff), .task_num_ff(task_num_ff), .irq_ff(irq_ff));
  // ----
  // Checking
  // ----
  function automatic void cmp(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endfunction
  task automatic complete_run;
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rdp && hreadyout) cmp("hrdata", rdq.pop_front(), hrdata);
    rdp <= hsel && htrans[1] && !hwrite && hreadyout;
    if (task_start_ff !== 8'h00) cmp("task_start", evq.size() ? evq.pop_front() : 32'h0, {24'h0, task_start_ff});
  end
  // ----
  // Bus and stimulus
  // ----
  task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!wr) rdq.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic cmd(input int i, input logic [11:0] a, input logic [15:0] c);
    xfer(1'b1, a, {13'h0, i[2:0], c});
  endtask
  task automatic pulse(input int i);
    sens_u.drive(i, 1'b1, 4 + $urandom % 8);
    sens_u.drive(i, 1'b0, 8);
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end
  initial begin
    void'($urandom(5900));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 12'h01c, 32'h0);
    xfer(1'b0, 12'h004, 32'h0);
    xfer(1'b1, 12'h010, 32'hff);
    for (int i = 0; i < 8; i++) begin
      cmd(i, 12'h004, {15'h0, i[0]});
      cmd(i, 12'h000, 16'h0000);
      evq.push_back(32'h1 << i);
      pulse(i);
      xfer(1'b0, 12'h014, 32'h8c + i);
    end
    xfer(1'b0, 12'h004, 32'hffaa);
    settle();
    cmp("irq", 32'h1, {31'h0, irq_ff});
    xfer(1'b1, 12'h010, 32'h0);
    settle();
    cmp("irq", 32'h0, {31'h0, irq_ff});
    xfer(1'b1, 12'h010, 32'hff);
    xfer(1'b1, 12'h00c, 32'hff);
    settle();
    cmp("irq", 32'h0, {31'h0, irq_ff});
    for (int c = 3; c >= 2; c--) begin
      t = 2 + $urandom % 3;
      xfer(1'b1, 12'h030, t);
      cmd(4, 12'h000, c[15:0]);
      evq.push_back(32'h10);
      repeat (t) pulse(4);
    end
    cmd(0, 12'h000, 16'h0001);
    pulse(0);
    xfer(1'b1, 12'h008, 32'h118440);
    sens_u.drive(2, 1'b1, 0);
    sens_u.drive(3, 1'b1, 0);
    sens_u.drive(5, 1'b1, 0);
    sens_u.drive(6, 1'b1, 6);
    @(negedge hclk);
    cmp("normal_in", 32'h4, {24'h0, normal_in_ff});
    cmp("quick_in", 32'h8, {24'h0, quick_in_ff});
    cmp("counter_in", 32'h20, {24'h0, counter_in_ff});
    cmp("origin_in", 32'h40, {24'h0, origin_in_ff});
    cmp("task_num", 32'h90, {24'h0, task_num_ff});
    sens_u.drive(2, 1'b0, 0);
    sens_u.drive(3, 1'b0, 0);
    sens_u.drive(5, 1'b0, 0);
    sens_u.drive(6, 1'b0, 8);
    cmp("pending", 32'h0, evq.size());
    complete_run;
  end
endmodule // tb_interrupt_input_unit
`default_nettype wire
